/* carrier_word_a_offset_adder.sv */
// Adds the signed fine offset to the base carrier word
`timescale 1ns/1ps
`default_nettype none
`include "synth_modem_defs.svh"

module carrier_word_a_offset_adder
(
	input wire logic [23:0] carrier_word_a_base_in,
	input wire logic [7:0] synth_carrier_word_a_offset_in,
	output logic [23:0] synth_word_out
);

	logic [25:0] sum;

	// One offset step is four carrier steps (2^14 against 2^16), so shift left by two
	// A negative result clamps at zero rather than wrapping to the top of the band
	always_comb
	begin
		sum = {2'b00, carrier_word_a_base_in} + {{16{synth_carrier_word_a_offset_in[7]}}, synth_carrier_word_a_offset_in, 2'b00};
		synth_word_out = sum[25] ? 24'h000000 : sum[23:0];
	end

endmodule : carrier_word_a_offset_adder
`default_nettype wire

/* modem_param_decoder.sv */
// Turns bandwidth, symbol rate and modulation fields into working values
`timescale 1ns/1ps
`default_nettype none
`include "synth_modem_defs.svh"

module modem_param_decoder
	import synth_modem_pkg::*;
(
	input wire logic [1:0] chan_bw_exponent_in,
	input wire logic [1:0] chan_bw_mantissa_in,
	input wire logic [3:0] symbol_rate_exponent_in,
	input wire logic [7:0] symbol_rate_mantissa_in,
	input wire logic [2:0] modulation_code_in,
	output logic [8:0] decimation_out,
	output logic [8:0] rate_mantissa_full_out,
	output logic [23:0] rate_increment_out,
	output modulation_select_t modulation_select_out,
	output logic modulation_reserved_out
);

	logic [2:0] bw_factor;

	// Decimation 8*(4+M)*2^E; largest value 448 fits nine bits
	always_comb
	begin
		bw_factor = `BW_BASE_FACTOR + {1'b0, chan_bw_mantissa_in};
		decimation_out = 9'({3'h0, bw_factor, 3'h0} << chan_bw_exponent_in);
	end

	// Hidden one above the mantissa; (256+M)<<E is the per-tick phase step of a 2^28 accumulator
	always_comb
	begin
		rate_mantissa_full_out = {`RATE_HIDDEN_ONE, symbol_rate_mantissa_in};
		rate_increment_out = 24'({15'h0000, rate_mantissa_full_out} << symbol_rate_exponent_in);
	end

	// Reserved codes fall back to 2-FSK but are flagged so the radio can refuse them
	always_comb
	begin
		modulation_reserved_out = 1'b0;
		case (modulation_code_in)
			3'b000: modulation_select_out = MOD_FSK2;
			3'b001: modulation_select_out = MOD_GFSK;
			3'b011: modulation_select_out = MOD_OOK;
			3'b100: modulation_select_out = MOD_FSK4;
			default:
			begin
				modulation_select_out = MOD_FSK2;
				modulation_reserved_out = 1'b1;
			end
		endcase
	end

endmodule : modem_param_decoder
`default_nettype wire

/* synth_modem_config_regs.sv */
// Synthesizer and modem configuration register bank with derived settings
`timescale 1ns/1ps
`default_nettype none
`include "synth_modem_defs.svh"

// What this block does
// - Signed 8-bit offset is added to the base word before the synthesizer.
// - One offset step is crystal over 2^14, four carrier-word steps.
// - Top two bits of the 24-bit carrier word always read zero.
// - Carrier word is high bits 5:0, middle byte, low byte; step crystal/2^16.
// - Decimation from 2-bit exponent 7:6 and mantissa 5:4: 8*(4+M)*2^E.
// - Symbol rate mantissa carries a hidden one: (256+M)*2^E over 2^28.
// - Symbol-rate exponent sits in bits 3:0 of the bandwidth register.
// - Modem bit 7 low keeps the DC block active; high bypasses it.
// - Bits 6:4 pick 2-FSK, GFSK, OOK or 4-FSK; 010, 101, 110 and 111 reserved.
module synth_modem_config_regs
	import synth_modem_pkg::*;
(
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [5:0] reg_addr_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output synth_cfg_t synth_cfg_out,
	output modem_cfg_t modem_cfg_out
);

	// ------------------------------------------------------------------------
	// Stored registers
	// ------------------------------------------------------------------------
	logic [7:0] synth_offset_reg, synth_offset_next;
	logic [5:0] carrier_high_reg, carrier_high_next;
	logic [7:0] carrier_mid_reg, carrier_mid_next;
	logic [7:0] carrier_low_reg, carrier_low_next;
	logic [7:0] bw_rate_exp_reg, bw_rate_exp_next;
	logic [7:0] rate_mant_reg, rate_mant_next;
	logic [7:0] mod_cfg_reg, mod_cfg_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	synth_cfg_t synth_cfg_reg, synth_cfg_next;
	modem_cfg_t modem_cfg_reg, modem_cfg_next;

	// Combinational base carrier word and results of the two helpers
	logic [23:0] carrier_word_a;
	logic [23:0] synth_word;
	logic [8:0] decimation;
	logic [8:0] rate_mant_full;
	logic [23:0] rate_increment;
	modulation_select_t modulation_select;
	logic modulation_reserved;

	// Upper two bits are wired to zero so no write can ever reach them
	assign carrier_word_a = {2'b00, carrier_high_reg, carrier_mid_reg, carrier_low_reg};

	// ------------------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------------------

	// Write decode; a write to an unmapped address is dropped
	always_comb
	begin
		synth_offset_next = synth_offset_reg;
		carrier_high_next = carrier_high_reg;
		carrier_mid_next = carrier_mid_reg;
		carrier_low_next = carrier_low_reg;
		bw_rate_exp_next = bw_rate_exp_reg;
		rate_mant_next = rate_mant_reg;
		mod_cfg_next = mod_cfg_reg;
		if (reg_write_in)
		begin
			case (reg_addr_in)
				`SYNTH_OFFSET_ADDR: synth_offset_next = reg_wdata_in;
				`CARRIER_HIGH_ADDR: carrier_high_next = reg_wdata_in[5:0];
				`CARRIER_MID_ADDR: carrier_mid_next = reg_wdata_in;
				`CARRIER_LOW_ADDR: carrier_low_next = reg_wdata_in;
				`BW_RATE_EXP_ADDR: bw_rate_exp_next = reg_wdata_in;
				`RATE_MANT_ADDR: rate_mant_next = reg_wdata_in;
				`MOD_CFG_ADDR: mod_cfg_next = reg_wdata_in;
				default: synth_offset_next = synth_offset_reg;
			endcase
		end
	end

	// Register storage
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			synth_offset_reg <= `SYNTH_OFFSET_RST;
			carrier_high_reg <= `CARRIER_HIGH_RST;
			carrier_mid_reg <= `CARRIER_MID_RST;
			carrier_low_reg <= `CARRIER_LOW_RST;
			bw_rate_exp_reg <= `BW_RATE_EXP_RST;
			rate_mant_reg <= `RATE_MANT_RST;
			mod_cfg_reg <= `MOD_CFG_RST;
		end
		else
		begin
			synth_offset_reg <= synth_offset_next;
			carrier_high_reg <= carrier_high_next;
			carrier_mid_reg <= carrier_mid_next;
			carrier_low_reg <= carrier_low_next;
			bw_rate_exp_reg <= bw_rate_exp_next;
			rate_mant_reg <= rate_mant_next;
			mod_cfg_reg <= mod_cfg_next;
		end
	end

	// ------------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------------

	// Registered read data; unmapped addresses read zero
	always_comb
	begin
		rvalid_next = reg_read_in;
		rdata_next = `READ_ZERO;
		if (reg_read_in)
		begin
			case (reg_addr_in)
				`SYNTH_OFFSET_ADDR: rdata_next = synth_offset_reg;
				`CARRIER_HIGH_ADDR: rdata_next = carrier_word_a[23:16];
				`CARRIER_MID_ADDR: rdata_next = carrier_mid_reg;
				`CARRIER_LOW_ADDR: rdata_next = carrier_low_reg;
				`BW_RATE_EXP_ADDR: rdata_next = bw_rate_exp_reg;
				`RATE_MANT_ADDR: rdata_next = rate_mant_reg;
				`MOD_CFG_ADDR: rdata_next = mod_cfg_reg;
				default: rdata_next = `READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign reg_rvalid_out = rvalid_reg;

	// ------------------------------------------------------------------------
	// Derived settings
	// ------------------------------------------------------------------------

	carrier_word_a_offset_adder u_offset_adder
	(
		.carrier_word_a_base_in(carrier_word_a),
		.synth_carrier_word_a_offset_in(synth_offset_reg),
		.synth_word_out(synth_word)
	);

	modem_param_decoder u_param_decoder
	(
		.chan_bw_exponent_in(bw_rate_exp_reg[`BW_EXP_MSB:`BW_EXP_LSB]),
		.chan_bw_mantissa_in(bw_rate_exp_reg[`BW_MANT_MSB:`BW_MANT_LSB]),
		.symbol_rate_exponent_in(bw_rate_exp_reg[`RATE_EXP_MSB:`RATE_EXP_LSB]),
		.symbol_rate_mantissa_in(rate_mant_reg),
		.modulation_code_in(mod_cfg_reg[`MOD_SEL_MSB:`MOD_SEL_LSB]),
		.decimation_out(decimation),
		.rate_mantissa_full_out(rate_mant_full),
		.rate_increment_out(rate_increment),
		.modulation_select_out(modulation_select),
		.modulation_reserved_out(modulation_reserved)
	);

	// Derived values are re-registered so the radio sees glitch-free settings,
	// at the cost of one cycle of lag after each write
	always_comb
	begin
		synth_cfg_next.carrier_word_a_base = carrier_word_a;
		synth_cfg_next.synth_word = synth_word;
		modem_cfg_next.chan_bw_exponent = bw_rate_exp_reg[`BW_EXP_MSB:`BW_EXP_LSB];
		modem_cfg_next.chan_bw_mantissa = bw_rate_exp_reg[`BW_MANT_MSB:`BW_MANT_LSB];
		modem_cfg_next.decimation = decimation;
		modem_cfg_next.symbol_rate_exponent = bw_rate_exp_reg[`RATE_EXP_MSB:`RATE_EXP_LSB];
		modem_cfg_next.symbol_rate_mantissa = rate_mant_full;
		modem_cfg_next.rate_increment = rate_increment;
		modem_cfg_next.dc_block_disable = mod_cfg_reg[`DC_BLOCK_BIT];
		modem_cfg_next.modulation_select = modulation_select;
		modem_cfg_next.modulation_reserved = modulation_reserved;
	end

	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			synth_cfg_reg <= '0;
			modem_cfg_reg <= '0;
		end
		else
		begin
			synth_cfg_reg <= synth_cfg_next;
			modem_cfg_reg <= modem_cfg_next;
		end
	end

	assign synth_cfg_out = synth_cfg_reg;
	assign modem_cfg_out = modem_cfg_reg;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	// Helper: flag set from the first edge after reset, so $past values are valid
	logic past_valid_reg;
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
			past_valid_reg <= 1'b0;
		else
			past_valid_reg <= 1'b1;
	end

	property p_offset_zero;
		past_valid_reg && synth_offset_reg == 8'h00 |=> synth_cfg_out.synth_word == $past(carrier_word_a);
	endproperty
	a_offset_zero: assert property (p_offset_zero) else $error("zero offset changed synth word");

	property p_offset_step;
		past_valid_reg && synth_offset_reg == 8'hFF && carrier_word_a >= 24'h000004
			|=> synth_cfg_out.synth_word == $past(carrier_word_a) - 24'h000004;
	endproperty
	a_offset_step: assert property (p_offset_step) else $error("offset step is not four carrier steps");

	property p_high_zero;
		reg_read_in && reg_addr_in == `CARRIER_HIGH_ADDR |=> reg_rvalid_out && reg_rdata_out[7:6] == 2'b00;
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("carrier top bits read nonzero");

	property p_low_byte;
		reg_write_in && reg_addr_in == `CARRIER_LOW_ADDR
			|-> ##2 synth_cfg_out.carrier_word_a_base[7:0] == $past(reg_wdata_in, 2);
	endproperty
	a_low_byte: assert property (p_low_byte) else $error("low carrier byte not assembled");

	property p_decimation;
		past_valid_reg |=> modem_cfg_out.decimation ==
			9'({3'h0, 3'($past(bw_rate_exp_reg[5:4]) + 3'h4), 3'h0} << $past(bw_rate_exp_reg[7:6]));
	endproperty
	a_decimation: assert property (p_decimation) else $error("decimation ratio wrong");

	property p_rate_hidden;
		reg_write_in && reg_addr_in == `RATE_MANT_ADDR
			|-> ##2 modem_cfg_out.symbol_rate_mantissa == {1'b1, $past(reg_wdata_in, 2)};
	endproperty
	a_rate_hidden: assert property (p_rate_hidden) else $error("hidden one missing");

	property p_rate_exp;
		reg_write_in && reg_addr_in == `BW_RATE_EXP_ADDR
			|-> ##2 modem_cfg_out.symbol_rate_exponent == $past(reg_wdata_in[3:0], 2);
	endproperty
	a_rate_exp: assert property (p_rate_exp) else $error("symbol exponent not from bits 3:0");

	property p_dc_block;
		reg_write_in && reg_addr_in == `MOD_CFG_ADDR
			|-> ##2 modem_cfg_out.dc_block_disable == $past(reg_wdata_in[7], 2);
	endproperty
	a_dc_block: assert property (p_dc_block) else $error("DC block control wrong");

	property p_mod_reserved;
		past_valid_reg |=> modem_cfg_out.modulation_reserved ==
			($past(mod_cfg_reg[6:4]) inside {3'b010, 3'b101, 3'b110, 3'b111});
	endproperty
	a_mod_reserved: assert property (p_mod_reserved) else $error("reserved modulation not flagged");

	property p_high_ignore;
		reg_write_in && reg_addr_in == `CARRIER_HIGH_ADDR
			|=> carrier_word_a[23:22] == 2'b00 && carrier_high_reg == $past(reg_wdata_in[5:0]);
	endproperty
	a_high_ignore: assert property (p_high_ignore) else $error("read-only carrier bits written");

	// Read data is the byte held before the taking edge, even if a write lands on that same edge
	property p_low_readback;
		reg_read_in && reg_addr_in == `CARRIER_LOW_ADDR |=> reg_rdata_out == $past(carrier_low_reg);
	endproperty
	a_low_readback: assert property (p_low_readback) else $error("low carrier byte read back wrong");

	// A legal code must reach the radio unchanged; only reserved codes may fall back
	property p_mod_select;
		past_valid_reg && !(mod_cfg_reg[6:4] inside {3'b010, 3'b101, 3'b110, 3'b111})
			|=> modem_cfg_out.modulation_select == $past(mod_cfg_reg[6:4]);
	endproperty
	a_mod_select: assert property (p_mod_select) else $error("legal modulation code not passed on");

	c_high_write: cover property (reg_write_in && reg_addr_in == `CARRIER_HIGH_ADDR && reg_wdata_in[7]);
	c_mod_read: cover property (reg_read_in && reg_addr_in == `MOD_CFG_ADDR ##1 reg_rvalid_out);
	c_reserved: cover property (modem_cfg_out.modulation_reserved);
	c_neg_offset: cover property (synth_offset_reg[7] ##1 synth_cfg_out.synth_word != 24'h000000);
	c_dc_bypass: cover property (modem_cfg_out.dc_block_disable);

endmodule : synth_modem_config_regs
`default_nettype wire

/* synth_modem_config_regs_bench.sv */
// Self-checking bench for the synthesizer and modem configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "synth_modem_defs.svh"

module synth_modem_config_regs_bench
	import synth_modem_pkg::*;
;
	// ------------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------------
	logic clock;
	logic resetn;
	logic [5:0] addr;
	logic wr_en;
	logic rd_en;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	synth_cfg_t synth_cfg;
	modem_cfg_t modem_cfg;
	int fails;
	int cmp_count;
	logic [7:0] shadow [7];
	logic [7:0] rst_val [7] = '{8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h02};

	synth_modem_config_regs i_synth_modem_config_regs (
		.clock_in(clock),
		.resetn_in(resetn),
		.reg_addr_in(addr),
		.reg_write_in(wr_en),
		.reg_read_in(rd_en),
		.reg_wdata_in(wdata),
		.reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid),
		.synth_cfg_out(synth_cfg),
		.modem_cfg_out(modem_cfg)
	);

	// ------------------------------------------------------------------
	// Expected values
	// ------------------------------------------------------------------
	// Offset steps are four carrier-word steps; a negative sum clamps to zero
	function automatic synth_cfg_t exp_synth();
		synth_cfg_t s;
		logic signed [25:0] sum;
		s.carrier_word_a_base = {2'b00, shadow[1][5:0], shadow[2], shadow[3]};
		sum = $signed({2'b00, s.carrier_word_a_base}) + ($signed(shadow[0]) <<< 2);
		s.synth_word = sum[25] ? 24'h000000 : sum[23:0];
		return s;
	endfunction : exp_synth

	function automatic modem_cfg_t exp_modem();
		modem_cfg_t m;
		logic [2:0] code;
		code = shadow[6][6:4];
		m.chan_bw_exponent = shadow[4][7:6];
		m.chan_bw_mantissa = shadow[4][5:4];
		m.decimation = 9'((8 * (4 + int'(shadow[4][5:4]))) << shadow[4][7:6]);
		m.symbol_rate_exponent = shadow[4][3:0];
		m.symbol_rate_mantissa = {1'b1, shadow[5]};
		m.rate_increment = 24'((256 + int'(shadow[5])) << shadow[4][3:0]);
		m.dc_block_disable = shadow[6][7];
		m.modulation_reserved = (code == 3'b010) || (code > 3'b100);
		m.modulation_select = modulation_select_t'(m.modulation_reserved ? 3'b000 : code);
		return m;
	endfunction : exp_modem

	// Unmapped offsets read back as zero
	function automatic logic [7:0] exp_read(input logic [5:0] a);
		if (a >= `SYNTH_OFFSET_ADDR && a <= `MOD_CFG_ADDR)
			return shadow[a - `SYNTH_OFFSET_ADDR];
		return 8'h00;
	endfunction : exp_read

	// ------------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	// Strobe is raised after one edge and dropped after the next, so never twice per step
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clock);
		#1;
		wr_en = 1'b0;
		wdata = ~d;
		if (a >= `SYNTH_OFFSET_ADDR && a <= `MOD_CFG_ADDR)
			shadow[a - `SYNTH_OFFSET_ADDR] = (a == `CARRIER_HIGH_ADDR) ? (d & 8'h3F) : d;
	endtask : wr

	// Answer stands for exactly one cycle after the taking edge
	task automatic rd(input logic [5:0] a);
		@(posedge clock);
		#1;
		addr = a;
		rd_en = 1'b1;
		@(posedge clock);
		#1;
		rd_en = 1'b0;
		check("rvalid", 64'(rvalid), 64'h1);
		check("rdata", 64'(rdata), 64'(exp_read(a)));
		// One edge later the answer must be gone again
		@(posedge clock);
		#1;
		check("rvalid_drop", 64'(rvalid), 64'h0);
		check("rdata_drop", 64'(rdata), 64'h0);
	endtask : rd

	// Derived outputs follow one edge after the register update
	task automatic check_cfg();
		@(posedge clock);
		#1;
		check("synth_cfg", 64'(synth_cfg), 64'(exp_synth()));
		check("modem_cfg", 64'(modem_cfg), 64'(exp_modem()));
	endtask : check_cfg

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Whole run is far shorter than this; running out counts as a failure
	initial
	begin
		#200000;
		fails++;
		finish_test();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		logic [5:0] a;
		fails = 0;
		cmp_count = 0;
		resetn = 1'b0;
		addr = 6'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wdata = 8'h00;
		void'($urandom(37));
		foreach (shadow[i])
			shadow[i] = rst_val[i];
		repeat (6) @(posedge clock);
		#1;
		// Outputs are cleared while reset is held
		check("reset_rvalid", 64'(rvalid), 64'h0);
		check("reset_synth", 64'(synth_cfg), 64'h0);
		check("reset_modem", 64'(modem_cfg), 64'h0);
		resetn = 1'b1;
		// Reset values of every register and of the derived words
		for (int i = 0; i < 7; i++)
			rd(6'(`SYNTH_OFFSET_ADDR + i));
		check_cfg();
		// Read-only top carrier bits ignore writes
		wr(`CARRIER_HIGH_ADDR, 8'hFF);
		rd(`CARRIER_HIGH_ADDR);
		check_cfg();
		// Offset extremes, including an exact zero and a clamped negative sum
		wr(`CARRIER_HIGH_ADDR, 8'hC0);
		wr(`CARRIER_MID_ADDR, 8'h00);
		wr(`CARRIER_LOW_ADDR, 8'h10);
		wr(`SYNTH_OFFSET_ADDR, 8'hFC);
		check_cfg();
		wr(`SYNTH_OFFSET_ADDR, 8'h80);
		check_cfg();
		wr(`SYNTH_OFFSET_ADDR, 8'h7F);
		check_cfg();
		// Field extremes of bandwidth and symbol rate
		wr(`BW_RATE_EXP_ADDR, 8'hFF);
		wr(`RATE_MANT_ADDR, 8'hFF);
		check_cfg();
		wr(`BW_RATE_EXP_ADDR, 8'h0F);
		wr(`RATE_MANT_ADDR, 8'h00);
		check_cfg();
		// Every modulation code with the filter bypass toggled
		for (int i = 0; i < 8; i++)
		begin
			wr(`MOD_CFG_ADDR, {i[0], 3'(i), 4'hA});
			check_cfg();
			rd(`MOD_CFG_ADDR);
		end
		// Unmapped places read zero and swallow writes
		wr(6'h13, 8'h55);
		check_cfg();
		rd(6'h13);
		rd(6'h3F);
		// Random traffic over the map and one unmapped offset
		repeat (60)
		begin
			a = 6'(`SYNTH_OFFSET_ADDR + $urandom_range(0, 7));
			wr(a, 8'($urandom));
			check_cfg();
			rd(a);
		end
		finish_test();
	end
endmodule : synth_modem_config_regs_bench
`default_nettype wire

/* synth_modem_defs.svh */
// Register offsets, field positions, reset values and widths of the synthesizer/modem bank
`ifndef SYNTH_MODEM_DEFS_SVH
`define SYNTH_MODEM_DEFS_SVH

// ----------------------------------------------------------------------------
// Access port geometry
// ----------------------------------------------------------------------------
`define REG_ADDR_W 6
`define REG_DATA_W 8
`define READ_ZERO 8'h00

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SYNTH_OFFSET_ADDR 6'h0C
`define CARRIER_HIGH_ADDR 6'h0D
`define CARRIER_MID_ADDR 6'h0E
`define CARRIER_LOW_ADDR 6'h0F
`define BW_RATE_EXP_ADDR 6'h10
`define RATE_MANT_ADDR 6'h11
`define MOD_CFG_ADDR 6'h12

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SYNTH_OFFSET_RST 8'h00
`define CARRIER_HIGH_RST 6'h1E
`define CARRIER_MID_RST 8'hC4
`define CARRIER_LOW_RST 8'hEC
`define BW_RATE_EXP_RST 8'h8C
`define RATE_MANT_RST 8'h22
`define MOD_CFG_RST 8'h02

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define CARRIER_HIGH_W 6
`define CARRIER_W 24
`define BW_EXP_MSB 7
`define BW_EXP_LSB 6
`define BW_MANT_MSB 5
`define BW_MANT_LSB 4
`define RATE_EXP_MSB 3
`define RATE_EXP_LSB 0
`define DC_BLOCK_BIT 7
`define MOD_SEL_MSB 6
`define MOD_SEL_LSB 4
`define DECIM_W 9
`define RATE_INCR_W 24
`define BW_BASE_FACTOR 3'h4
`define RATE_HIDDEN_ONE 1'h1

`endif

/* synth_modem_pkg.sv */
// Types shared by the synthesizer/modem configuration bank
package synth_modem_pkg;

	// Modulation formats with their register codes
	typedef enum logic [2:0] {
		MOD_FSK2 = 3'b000,
		MOD_GFSK = 3'b001,
		MOD_OOK = 3'b011,
		MOD_FSK4 = 3'b100
	} modulation_select_t;

	// Words handed to the frequency synthesizer
	typedef struct packed {
		logic [23:0] carrier_word_a_base;
		logic [23:0] synth_word;
	} synth_cfg_t;

	// Settings handed to the demodulator and symbol timing
	typedef struct packed {
		logic [1:0] chan_bw_exponent;
		logic [1:0] chan_bw_mantissa;
		logic [8:0] decimation;
		logic [3:0] symbol_rate_exponent;
		logic [8:0] symbol_rate_mantissa;
		logic [23:0] rate_increment;
		logic dc_block_disable;
		modulation_select_t modulation_select;
		logic modulation_reserved;
	} modem_cfg_t;

endpackage : synth_modem_pkg
